// ---- src/cbf_params.svh ----
// Constants for the flag-clear conditional branch unit.
// Assumes a 16-bit program word and a byte-addressed program counter.
`ifndef CBF_PARAMS_SVH
`define CBF_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CBF_PC_W        21
`define CBF_WORD_W      16
`define CBF_LIT_W       8
`define CBF_SEXT_W      12

// ****************************************************************
// Opcode upper bytes and field positions
// ****************************************************************
`define CBF_OP_NN       8'he7
`define CBF_OP_NOV      8'he5
`define CBF_OP_NZ       8'he1
`define CBF_OP_HI       15
`define CBF_OP_LO       8
`define CBF_LIT_HI      7
`define CBF_LIT_LO      0

// ****************************************************************
// Addressing and quarter phases
// ****************************************************************
`define CBF_PC_STEP     2
`define CBF_Q1          2'h0
`define CBF_Q2          2'h1
`define CBF_Q3          2'h2
`define CBF_Q4          2'h3
`define CBF_PHASES      4
`define CBF_PC_RST      21'h000000
`define CBF_LIT_RST     8'h00

`endif

// ---- src/cbf_pkg.sv ----
// Types shared by the flag-clear conditional branch unit.
// Assumes cbf_params.svh is on the include path.
`include "cbf_params.svh"

package cbf_pkg;

    // ****************************************************************
    // Sequencer states and tested condition
    // ****************************************************************
    typedef enum logic [1:0] {
        CBF_IDLE = 2'b00,
        CBF_EXEC = 2'b01,
        CBF_NOP  = 2'b10
    } cbf_state_e;

    typedef enum logic [1:0] {
        CBF_COND_NN  = 2'b00,
        CBF_COND_NOV = 2'b01,
        CBF_COND_NZ  = 2'b10
    } cbf_cond_e;

    typedef logic [`CBF_PC_W-1:0] cbf_pc_t;

    // ****************************************************************
    // Whole state of the branch unit
    // ****************************************************************
    typedef struct packed {
        cbf_state_e            st;
        cbf_cond_e             cond;
        cbf_pc_t               addr;
        logic [`CBF_LIT_W-1:0] lit;
        cbf_pc_t               target;
        logic                  take;
        cbf_pc_t               pc_value;
        logic                  pc_load;
        logic                  done;
        logic                  busy;
        logic                  accept;
        logic                  taken;
        logic                  nop_cyc;
        logic                  flags_we;
    } cbf_state_s;

endpackage

// ---- src/cbf_qphase.sv ----
// Quarter-phase sequencer: splits the clock into four-phase instruction cycles.
// Assumes one clock; phase Q1 follows the release of reset.
`timescale 1ns/1ns
`include "cbf_params.svh"

module cbf_qphase #(
    parameter int PHASES = `CBF_PHASES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    output logic [1:0]      phase
);

    logic [1:0] phase_reg;
    logic [1:0] phase_next;

    // Wraps after the last phase; the count is the instruction-cycle enable
    always_comb begin
        if (phase_reg == 2'(PHASES - 1)) begin
            phase_next = `CBF_Q1;
        end else begin
            phase_next = phase_reg + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= `CBF_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;

endmodule

// ---- src/cbf_branch_unit.sv ----
// Decode and execute of the three flag-clear relative branches.
// Assumes fetch, flags and program counter logic share clk; no synchronisers.
`timescale 1ns/1ns
`include "cbf_params.svh"

module cbf_branch_unit (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   instr_valid,
    input  wire logic [`CBF_WORD_W-1:0] instr_word,
    input  wire cbf_pkg::cbf_pc_t       instr_addr,
    input  wire logic                   flag_negative,
    input  wire logic                   flag_overflow,
    input  wire logic                   flag_zero,
    output logic                        accept,
    output logic                        busy,
    output logic                        pc_load,
    output cbf_pkg::cbf_pc_t            pc_value,
    output logic                        taken,
    output logic                        nop_cycle,
    output logic                        done,
    output logic                        flags_write_en
);
    import cbf_pkg::*;

    cbf_state_s s_reg;
    cbf_state_s s_next;
    logic [1:0] q_phase;
    logic [`CBF_OP_HI-`CBF_OP_LO:0] op_hi;
    logic       is_branch;
    cbf_cond_e  dec_cond;
    logic       cond_ok;
    cbf_pc_t    rel_off;
    cbf_pc_t    seq_addr;

    // ****************************************************************
    // Quarter phases
    // ****************************************************************
    cbf_qphase #(
        .PHASES (`CBF_PHASES)
    ) u_qphase (
        .clk    (clk),
        .resetn (resetn),
        .phase  (q_phase)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************
    // Only the upper byte selects; the low byte is always the offset
    always_comb begin
        op_hi     = instr_word[`CBF_OP_HI:`CBF_OP_LO];
        is_branch = 1'b1;
        dec_cond  = CBF_COND_NN;
        unique case (op_hi)
            `CBF_OP_NOV: dec_cond = CBF_COND_NOV;
            `CBF_OP_NZ:  dec_cond = CBF_COND_NZ;
            `CBF_OP_NN:  dec_cond = CBF_COND_NN;
            default:     is_branch = 1'b0;
        endcase
    end

    // ****************************************************************
    // Condition and address arithmetic
    // ****************************************************************
    // Flags are sampled in Q3 only, so a flag update from the previous
    // instruction has settled by then
    always_comb begin
        unique case (s_reg.cond)
            CBF_COND_NOV: cond_ok = !flag_overflow;
            CBF_COND_NZ:  cond_ok = !flag_zero;
            CBF_COND_NN:  cond_ok = !flag_negative;
            default:      cond_ok = 1'b0;
        endcase
    end

    // Offset doubled: low bit zero keeps targets word aligned
    assign rel_off  = {{(`CBF_PC_W-`CBF_LIT_W-1){s_reg.lit[`CBF_LIT_HI]}},
                       s_reg.lit, 1'b0};
    assign seq_addr = s_reg.addr + `CBF_PC_W'(`CBF_PC_STEP);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        s_next          = s_reg;
        s_next.pc_load  = 1'b0;
        s_next.done     = 1'b0;
        s_next.accept   = 1'b0;
        s_next.flags_we = 1'b0;
        unique case (s_reg.st)
            CBF_IDLE: begin
                // Q1: decode a fresh word
                if (q_phase == `CBF_Q1 && instr_valid && is_branch) begin
                    s_next.st      = CBF_EXEC;
                    s_next.cond    = dec_cond;
                    s_next.addr    = instr_addr;
                    s_next.accept  = 1'b1;
                    s_next.busy    = 1'b1;
                    s_next.taken   = 1'b0;
                    s_next.nop_cyc = 1'b0;
                end
            end
            CBF_EXEC: begin
                if (q_phase == `CBF_Q2) begin
                    // Q2: read the literal from the held word
                    s_next.lit = instr_word[`CBF_LIT_HI:`CBF_LIT_LO];
                end else if (q_phase == `CBF_Q3) begin
                    // Q3: test the flag and form the target
                    s_next.take   = cond_ok;
                    s_next.target = seq_addr + rel_off;
                end else if (q_phase == `CBF_Q4) begin
                    if (s_reg.take) begin
                        s_next.pc_value = s_reg.target;
                        s_next.pc_load  = 1'b1;
                        s_next.taken    = 1'b1;
                        s_next.nop_cyc  = 1'b1;
                        s_next.st       = CBF_NOP;
                    end else begin
                        // Q4 idle; the sequential address stands
                        s_next.pc_value = seq_addr;
                        s_next.done     = 1'b1;
                        s_next.busy     = 1'b0;
                        s_next.st       = CBF_IDLE;
                    end
                end
            end
            CBF_NOP: begin
                // Whole cycle idle while fetch refills behind the jump
                if (q_phase == `CBF_Q4) begin
                    s_next.nop_cyc = 1'b0;
                    s_next.done    = 1'b1;
                    s_next.busy    = 1'b0;
                    s_next.st      = CBF_IDLE;
                end
            end
            default: s_next.st = CBF_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg          <= '0;
            s_reg.st       <= CBF_IDLE;
            s_reg.cond     <= CBF_COND_NN;
            s_reg.addr     <= `CBF_PC_RST;
            s_reg.lit      <= `CBF_LIT_RST;
            s_reg.target   <= `CBF_PC_RST;
            s_reg.pc_value <= `CBF_PC_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs, all straight from the state register
    // ****************************************************************
    assign accept         = s_reg.accept;
    assign busy           = s_reg.busy;
    assign pc_load        = s_reg.pc_load;
    assign pc_value       = s_reg.pc_value;
    assign taken          = s_reg.taken;
    assign nop_cycle      = s_reg.nop_cyc;
    assign done           = s_reg.done;
    assign flags_write_en = s_reg.flags_we;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_decode_nov;
        @(posedge clk) disable iff (!resetn)
        (q_phase == `CBF_Q1 && s_reg.st == CBF_IDLE && instr_valid &&
         instr_word[`CBF_OP_HI:`CBF_OP_LO] == `CBF_OP_NOV)
        |=> (accept && busy && s_reg.cond == CBF_COND_NOV);
    endproperty
    a_decode_nov: assert property (p_decode_nov) else $error("overflow-clear not decoded");

    property p_cond_nov;
        @(posedge clk) disable iff (!resetn)
        (s_reg.st == CBF_EXEC && q_phase == `CBF_Q3 && s_reg.cond == CBF_COND_NOV)
        |=> (s_reg.take == !$past(flag_overflow));
    endproperty
    a_cond_nov: assert property (p_cond_nov) else $error("overflow test wrong");

    property p_cond_nz;
        @(posedge clk) disable iff (!resetn)
        (s_reg.st == CBF_EXEC && q_phase == `CBF_Q3 && s_reg.cond == CBF_COND_NZ)
        |=> (s_reg.take == !$past(flag_zero));
    endproperty
    a_cond_nz: assert property (p_cond_nz) else $error("zero test wrong");

    property p_cond_nn;
        @(posedge clk) disable iff (!resetn)
        (s_reg.st == CBF_EXEC && q_phase == `CBF_Q3 && s_reg.cond == CBF_COND_NN)
        |=> (s_reg.take == !$past(flag_negative));
    endproperty
    a_cond_nn: assert property (p_cond_nn) else $error("negative test wrong");

    property p_target;
        @(posedge clk) disable iff (!resetn)
        pc_load |-> (pc_value == seq_addr + rel_off);
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    property p_fall_through;
        @(posedge clk) disable iff (!resetn)
        (done && !taken) |-> (pc_value == seq_addr && !$past(pc_load));
    endproperty
    a_fall_through: assert property (p_fall_through) else $error("fall-through pc wrong");

    property p_cycles;
        @(posedge clk) disable iff (!resetn)
        accept |-> ##3 ((done && !pc_load) or (pc_load ##4 done));
    endproperty
    a_cycles: assert property (p_cycles) else $error("instruction cycle count wrong");

    property p_pc_write_q4;
        @(posedge clk) disable iff (!resetn)
        pc_load |-> ($past(q_phase) == `CBF_Q4 && $past(s_reg.st) == CBF_EXEC);
    endproperty
    a_pc_write_q4: assert property (p_pc_write_q4) else $error("pc written outside Q4");

    property p_nop_cycle;
        @(posedge clk) disable iff (!resetn)
        pc_load |-> nop_cycle [*4] ##1 (!nop_cycle && !busy);
    endproperty
    a_nop_cycle: assert property (p_nop_cycle) else $error("idle cycle length wrong");

    property p_flags_kept;
        @(posedge clk) disable iff (!resetn)
        (busy || done) |-> !flags_write_en;
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags written");

endmodule

// ---- tb/conditional_branch_flag_clear_test.sv ----
// Self-checking bench for the flag-clear conditional branch unit.
// Assumes cbf_pkg and cbf_params.svh are compiled first; the bench plays fetch, flags and PC.
`timescale 1ns/1ns
`include "cbf_params.svh"

module conditional_branch_flag_clear_test;
    import cbf_pkg::*;

    typedef struct packed {
        cbf_pc_t pc;
        logic    tk;
    } cbf_note_s;

    logic                   clk            = 1'b0;
    logic                   resetn         = 1'b0;
    logic                   instr_valid    = 1'b0;
    logic [`CBF_WORD_W-1:0] instr_word     = 16'h0000;
    cbf_pc_t                instr_addr     = 21'h000000;
    logic                   flag_negative  = 1'b0;
    logic                   flag_overflow  = 1'b0;
    logic                   flag_zero      = 1'b0;
    logic                   accept;
    logic                   busy;
    logic                   pc_load;
    cbf_pc_t                pc_value;
    logic                   taken;
    logic                   nop_cycle;
    logic                   done;
    logic                   flags_write_en;
    logic [1:0]             ph;
    logic [15:0]            rnd            = 16'h0007;
    cbf_note_s              notes[$];
    int                     errors         = 0;
    int                     num_checks     = 0;
    int                     cyc            = 0;
    int                     nops           = 0;
    int                     loads          = 0;

    cbf_branch_unit DUT (
        .clk            (clk),
        .resetn         (resetn),
        .instr_valid    (instr_valid),
        .instr_word     (instr_word),
        .instr_addr     (instr_addr),
        .flag_negative  (flag_negative),
        .flag_overflow  (flag_overflow),
        .flag_zero      (flag_zero),
        .accept         (accept),
        .busy           (busy),
        .pc_load        (pc_load),
        .pc_value       (pc_value),
        .taken          (taken),
        .nop_cycle      (nop_cycle),
        .done           (done),
        .flags_write_en (flags_write_en)
    );

    // ****************************************************************
    // Clock, phase tracking and shared helpers
    // ****************************************************************
    // 125 MHz clock
    always #4 clk = ~clk;

    // Mirror of the quarter phase, so requests land on Q1 edges only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) ph <= 2'h0;
        else ph <= ph + 2'h1;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // Driver: one branch word per call, expectation noted first
    // ****************************************************************
    // Word and flags are held until completion so late sampling cannot hide a slip
    task automatic run(input logic [7:0] op, input logic [7:0] off, input cbf_pc_t a,
                       input logic [2:0] f, input bit hold);
        cbf_note_s n;
        int        i;
        n.tk = (op == 8'he7) ? !f[2] : (op == 8'he5) ? !f[1] : !f[0];
        n.pc = n.tk ? a + 21'h000002 + {{12{off[7]}}, off, 1'b0} : a + 21'h000002;
        do @(posedge clk); while (ph !== 2'h3);
        instr_valid <= 1'b1;
        instr_word  <= {op, off};
        instr_addr  <= a;
        {flag_negative, flag_overflow, flag_zero} <= f;
        if (op inside {8'he7, 8'he5, 8'he1}) notes.push_back(n);
        @(posedge clk);
        // Optionally keep asking through the next Q1 edge, while the unit is busy
        if (hold) repeat (4) @(posedge clk);
        instr_valid <= 1'b0;
        i = 0;
        while (notes.size() != 0 && i < 30) begin
            @(posedge clk);
            i++;
        end
        if (i >= 30) check(32'h0, 32'h1);
        repeat (8) @(posedge clk);
        instr_word <= ~{op, off};
    endtask

    // ****************************************************************
    // Monitor: counts cycles, idle cycles and loads, compares at done
    // ****************************************************************
    always @(posedge clk) begin
        cbf_note_s n;
        if (resetn) begin
            if (accept === 1'b1) begin
                if (notes.size() == 0) check(32'h1, 32'h0);
                check(busy, 1'b1);
                cyc   = 0;
                nops  = 0;
                loads = 0;
            end else cyc++;
            if (nop_cycle === 1'b1) nops++;
            if (pc_load === 1'b1) loads++;
            if (done === 1'b1 && notes.size() == 0) check(32'h1, 32'h0);
            if (done === 1'b1 && notes.size() != 0) begin
                n = notes.pop_front();
                check(pc_value, n.pc);
                check(taken, n.tk);
                check(cyc, n.tk ? 7 : 3);
                check(nops, n.tk ? 4 : 0);
                check(loads, n.tk);
                check(flags_write_en, 1'b0);
                check(busy, 1'b0);
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] ops[3];
        logic [7:0] offs[4];
        logic [7:0] bad[5];
        logic [2:0] mask;
        cbf_pc_t    a;
        ops  = '{8'he7, 8'he5, 8'he1};
        offs = '{8'h80, 8'h7f, 8'h00, 8'hff};
        bad  = '{8'he3, 8'he4, 8'he6, 8'hd0, 8'h00};
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // Each opcode, tested flag both ways, other flags opposite, offset extremes
        for (int o = 0; o < 3; o++) begin
            mask = 3'b100 >> o;
            for (int v = 0; v < 2; v++) begin
                for (int k = 0; k < 4; k++) begin
                    rnd = lfsr_next(rnd);
                    a = (k == 1) ? 21'h1ffffe : {4'h0, rnd, 1'b0};
                    run(ops[o], offs[k], a, v ? mask : ~mask, 1'b0);
                end
            end
        end
        $display("test opcodes and offsets done");
        // Random words, addresses and flags
        for (int r = 0; r < 30; r++) begin
            rnd = lfsr_next(rnd);
            a[20:16] = rnd[4:0];
            rnd = lfsr_next(rnd);
            a[15:0] = {rnd[15:1], 1'b0};
            run(ops[rnd[3:0] % 3], rnd[15:8], a, rnd[7:5], 1'b0);
        end
        $display("test random branches done");
        // Neighbouring and foreign opcodes must be ignored
        foreach (bad[b]) run(bad[b], 8'h22, 21'h000100, 3'b000, 1'b0);
        $display("test foreign opcodes done");
        // A request still raised while busy must not start a second branch
        run(8'he7, 8'h10, 21'h000400, 3'b000, 1'b1);
        $display("test request while busy done");
        // Second reset clears every output, then the unit works again
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        check({busy, taken, nop_cycle, done, pc_load, accept}, 6'h00);
        check(pc_value, 21'h000000);
        resetn <= 1'b1;
        run(8'he5, 8'hfe, 21'h000020, 3'b000, 1'b0);
        $display("test reset in run done");
        tally_and_finish;
    end

    // Watchdog: the whole sequence needs well under 2000 clocks
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end

endmodule
